// >>> logic/dms_pkg.sv
package dms_pkg;
  // Masters: 0 CPU, 1 DMA read port, 2 DMA write port
  localparam int NM = 3;
  // Number of response delay slots per master
  localparam int NSLOT = 3;
  // Linear byte address map
  localparam logic [15:0] NV_BASE = 16'h1000;
  localparam logic [15:0] SRAM_BASE = 16'h2000;
  localparam logic [15:0] SRAM_LAST = 16'h9fff;
  // Short register path, single-bit access and plain storage ranges
  localparam logic [15:0] SHORT_LAST = 16'h003f;
  localparam logic [15:0] BIT_LAST = 16'h001f;
  localparam logic [15:0] GP_LAST = 16'h000f;
  // Special register-space locations
  localparam logic [11:0] ID0_ADDR = 12'h090;
  localparam logic [11:0] ID1_ADDR = 12'h091;
  localparam logic [11:0] ID2_ADDR = 12'h092;
  localparam logic [11:0] REV_ADDR = 12'h093;
  localparam logic [11:0] LOCK_ADDR = 12'h0a0;
  // Lockable register windows
  localparam logic [11:0] CLK_LO = 12'h040;
  localparam logic [11:0] CLK_HI = 12'h07f;
  localparam logic [11:0] EV_LO = 12'h180;
  localparam logic [11:0] EV_HI = 12'h1bf;
  localparam logic [11:0] WEX_LO = 12'h880;
  localparam logic [11:0] WEX_HI = 12'h8bf;
  localparam logic [2:0] LOCK_RST = 3'h0;
  // Identity defaults, values arbitrary
  localparam logic [7:0] ID0_DEF = 8'h5a;
  localparam logic [7:0] ID1_DEF = 8'h3c;
  localparam logic [7:0] ID2_DEF = 8'h81;
  localparam logic [7:0] REV_DEF = 8'h01;
  // Access latencies in clock cycles
  localparam logic [1:0] LAT_IO = 2'h1;
  localparam logic [1:0] LAT_SRAM = 2'h2;
  localparam logic [1:0] LAT_NV = 2'h3;
  // Page geometry
  localparam int NV_PAGE_BYTES = 32;
  localparam int PM_PAGE_WORDS = 256;

  // Master operations
  typedef enum logic [2:0] {
    OP_RD = 3'b000,
    OP_WR = 3'b001,
    OP_SETB = 3'b010,
    OP_CLRB = 3'b011,
    OP_TSTB = 3'b100
  } dms_op_e;

  // Memory sets; the first four are arbitrated
  typedef enum logic [2:0] {
    SET_IO = 3'b000,
    SET_NV = 3'b001,
    SET_SR0 = 3'b010,
    SET_SR1 = 3'b011,
    SET_NONE = 3'b100
  } dms_set_e;

  // Nonvolatile data commit operations
  typedef enum logic [2:0] {
    NV_NONE = 3'b000,
    NV_WR_PAGE = 3'b001,
    NV_WR_BYTE = 3'b010,
    NV_ER_PAGE = 3'b011,
    NV_ER_BYTE = 3'b100
  } dms_nvop_e;

  // Program memory operations
  typedef enum logic [1:0] {
    PM_NONE = 2'b00,
    PM_READ = 2'b01,
    PM_WR_PAGE = 2'b10,
    PM_ER_PAGE = 2'b11
  } dms_pmop_e;

  // One master request
  typedef struct packed {
    logic valid;
    dms_op_e op;
    logic short_io;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dms_req_s;

  // One read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dms_rsp_s;

  // Program memory command
  typedef struct packed {
    logic valid;
    dms_pmop_e op;
    logic [10:0] program_page_index;
    logic [7:0] program_word_index;
    logic hi_byte;
  } dms_pm_cmd_s;

  // Control state of the router, storage arrays kept apart
  typedef struct packed {
    dms_rsp_s [NM-1:0][NSLOT-1:0] slot;
    logic nv_hold;
    logic [2:0] lock;
    logic [NV_PAGE_BYTES-1:0] loaded;
    dms_pm_cmd_s pm;
  } dms_state_s;
endpackage

// >>> logic/dms_arbiter.sv
`timescale 1ns/10ps
// Fixed priority: lowest index wins
module dms_arbiter #(
  parameter int N = 3
) (
  // Requests and grants
  input wire logic [N-1:0] req,
  output logic [N-1:0] gnt
);
  // Grant the first requester only
  always_comb begin
    logic taken;
    taken = 1'b0;
    gnt = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && !taken) begin
        gnt[i] = 1'b1;
        taken = 1'b1;
      end
    end
  end
endmodule

// >>> logic/dms_router.sv
`timescale 1ns/10ps
// What this block does
// RQ1 - Decode register, nonvolatile and SRAM windows
// RQ2 - Nonvolatile data mapped at 0x1000 when enabled
// RQ3 - Mapped loads read, stores fill page buffer
// RQ4 - Short path reaches registers 0x00 to 0x3F
// RQ5 - Bit set/clear/test on 0x00 to 0x1F
// RQ6 - Lowest 16 registers are plain storage
// RQ7 - Four memory sets accessed in parallel
// RQ8 - Register access completes in one cycle
// RQ9 - SRAM write one, read two, burst every cycle
// RQ10 - Buffer load one, read three, burst halved
// RQ11 - Locked clock/event/waveform registers ignore writes
// RQ12 - Lock register written only when protection open
// RQ13 - Three-byte identity plus revision register readable
// RQ14 - Program word Z[8:1], page Z[19:9]
// RQ15 - Program write/erase per page, read per byte
// RQ16 - Nonvolatile byte ADDR[4:0], page ADDR[11:5]
// RQ17 - Nonvolatile write/erase by page or byte
// RQ18 - Fixed priority per set: CPU first
// RQ19 - Losing master stalled, request kept intact
// RQ20 - Beyond SRAM: writes dropped, reads zero
module dms_router #(
  parameter logic [7:0] ID0 = dms_pkg::ID0_DEF,
  parameter logic [7:0] ID1 = dms_pkg::ID1_DEF,
  parameter logic [7:0] ID2 = dms_pkg::ID2_DEF,
  parameter logic [7:0] REV = dms_pkg::REV_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Master requests and answers
  input dms_pkg::dms_req_s [dms_pkg::NM-1:0] mreq,
  output logic [dms_pkg::NM-1:0] mready,
  output dms_pkg::dms_rsp_s [dms_pkg::NM-1:0] mrsp,
  // Nonvolatile data control
  input wire logic nv_map_en,
  input dms_pkg::dms_nvop_e nv_op,
  input wire logic [11:0] nv_op_addr,
  // Register protection
  input wire logic ccp_open,
  output logic [2:0] lock_state,
  // Program memory addressing
  input dms_pkg::dms_pmop_e pm_op,
  input wire logic [19:0] pm_z,
  output dms_pkg::dms_pm_cmd_s pm_cmd
);
  import dms_pkg::*;

  // Registered state and its next value
  dms_state_s s_reg;
  dms_state_s s_next;

  // Storage arrays
  logic [7:0] io_mem [4096];
  logic [7:0] sram0 [16384];
  logic [7:0] sram1 [16384];
  logic [7:0] nv_mem [4096];
  logic [7:0] nvb [NV_PAGE_BYTES];

  // Per-master decode
  logic [NM-1:0][15:0] ea;
  logic [NM-1:0][15:0] soff;
  dms_set_e dset [NM];
  logic [NM-1:0] isrd;
  logic [NM-1:0][1:0] lat;
  logic [NM-1:0] slot_ok;
  logic [NM-1:0][7:0] io_val;
  logic [NM-1:0][7:0] rd;
  logic [3:0][NM-1:0] areq;
  logic [3:0][NM-1:0] agnt;

  // Memory write controls
  logic io_we;
  logic [11:0] io_wa;
  logic [7:0] io_wd;
  logic s0_we;
  logic s1_we;
  logic [13:0] s0_wa;
  logic [13:0] s1_wa;
  logic [7:0] s0_wd;
  logic [7:0] s1_wd;
  logic nvb_we;
  logic [4:0] nvb_wa;
  logic [7:0] nvb_wd;

  // Commit address split
  logic [6:0] nv_data_page_index;
  logic [4:0] nv_data_byte_index;
  assign nv_data_page_index = nv_op_addr[11:5]; // see RQ16
  assign nv_data_byte_index = nv_op_addr[4:0]; // see RQ16

  // Decode each master's request and fetch its read value
  always_comb begin
    logic [3:0] occ;
    occ = '0;
    for (int m = 0; m < NM; m++) begin
      // Short path sees only the low 64 locations
      ea[m] = mreq[m].short_io ? {10'h000, mreq[m].addr[5:0]} : mreq[m].addr; // see RQ4
      soff[m] = ea[m] - SRAM_BASE;
      isrd[m] = (mreq[m].op == OP_RD) || (mreq[m].op == OP_TSTB);
      // Window decode
      if (mreq[m].op inside {OP_SETB, OP_CLRB, OP_TSTB} && ea[m] > BIT_LAST) begin
        dset[m] = SET_NONE; // see RQ5
      end else if (ea[m] < NV_BASE) begin
        dset[m] = SET_IO; // see RQ1
      end else if (ea[m] < SRAM_BASE) begin
        dset[m] = nv_map_en ? SET_NV : SET_NONE; // see RQ2
      end else if (ea[m] <= SRAM_LAST) begin
        dset[m] = soff[m][14] ? SET_SR1 : SET_SR0; // see RQ7
      end else begin
        dset[m] = SET_NONE; // see RQ20
      end
      // Latency of a read by set
      case (dset[m])
        SET_NV: lat[m] = LAT_NV; // see RQ10
        SET_SR0, SET_SR1: lat[m] = LAT_SRAM; // see RQ9
        default: lat[m] = LAT_IO; // see RQ8
      endcase
      // A read may start only if its answer slot is free
      occ = {1'b0, s_reg.slot[m][2].valid, s_reg.slot[m][1].valid, s_reg.slot[m][0].valid};
      slot_ok[m] = !isrd[m] || !occ[lat[m]];
      // Register space read value, identity and lock overlaid
      case (ea[m][11:0])
        ID0_ADDR: io_val[m] = ID0; // see RQ13
        ID1_ADDR: io_val[m] = ID1; // see RQ13
        ID2_ADDR: io_val[m] = ID2; // see RQ13
        REV_ADDR: io_val[m] = REV; // see RQ13
        LOCK_ADDR: io_val[m] = {5'h00, s_reg.lock};
        default: io_val[m] = io_mem[ea[m][11:0]];
      endcase
      // Read data by set
      case (dset[m])
        SET_IO: rd[m] = (mreq[m].op == OP_TSTB) ? {7'h00, io_val[m][mreq[m].bit_sel]} : io_val[m]; // see RQ5
        SET_NV: rd[m] = nv_mem[ea[m][11:0]]; // see RQ3
        SET_SR0: rd[m] = sram0[soff[m][13:0]];
        SET_SR1: rd[m] = sram1[soff[m][13:0]];
        default: rd[m] = 8'h00; // see RQ20
      endcase
      // Requests to the four arbitrated sets
      for (int k = 0; k < 4; k++) begin
        areq[k][m] = mreq[m].valid && slot_ok[m] && (dset[m] == dms_set_e'(3'(k)))
                     && !(k == 1 && s_reg.nv_hold); // see RQ10
      end
    end
  end

  // One fixed-priority arbiter per memory set
  for (genvar k = 0; k < 4; k++) begin : g_arb
    dms_arbiter #(.N(NM)) u_arb (
      .req(areq[k]),
      .gnt(agnt[k])
    ); // see RQ18
  end

  // A master proceeds when granted, or when its request maps to no set and its slot is free; otherwise it is stalled
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      if (dset[m] == SET_NONE) begin
        mready[m] = mreq[m].valid && slot_ok[m];
      end else begin
        mready[m] = agnt[dset[m][1:0]][m]; // see RQ19
      end
    end
  end

  // Next state and memory write controls
  always_comb begin
    logic prot;
    prot = 1'b0;
    s_next = s_reg;
    io_we = 1'b0;
    io_wa = '0;
    io_wd = '0;
    s0_we = 1'b0;
    s0_wa = '0;
    s0_wd = '0;
    s1_we = 1'b0;
    s1_wa = '0;
    s1_wd = '0;
    nvb_we = 1'b0;
    nvb_wa = '0;
    nvb_wd = '0;
    s_next.nv_hold = 1'b0;
    // Committed buffer bytes are consumed
    if (nv_op == NV_WR_PAGE) begin
      s_next.loaded = '0;
    end else if (nv_op == NV_WR_BYTE) begin
      s_next.loaded[nv_data_byte_index] = 1'b0;
    end
    for (int m = 0; m < NM; m++) begin
      // Answer slots move one step toward the output
      for (int i = 0; i < NSLOT - 1; i++) begin
        s_next.slot[m][i] = s_reg.slot[m][i + 1];
      end
      s_next.slot[m][NSLOT - 1] = '0;
      if (mready[m] && isrd[m]) begin
        // Answer appears lat cycles after acceptance
        s_next.slot[m][lat[m] - 2'h1] = {1'b1, rd[m]}; // see RQ8
        if (dset[m] == SET_NV) begin
          s_next.nv_hold = 1'b1; // see RQ10
        end
      end else if (mready[m]) begin
        case (dset[m])
          SET_IO: begin
            prot = ((ea[m][11:0] >= CLK_LO) && (ea[m][11:0] <= CLK_HI) && s_reg.lock[0])
                   || ((ea[m][11:0] >= EV_LO) && (ea[m][11:0] <= EV_HI) && s_reg.lock[1])
                   || ((ea[m][11:0] >= WEX_LO) && (ea[m][11:0] <= WEX_HI) && s_reg.lock[2]);
            if (ea[m][11:0] == LOCK_ADDR) begin
              if (ccp_open) begin
                s_next.lock = mreq[m].wdata[2:0]; // see RQ12
              end
            end else if (ea[m][11:0] inside {ID0_ADDR, ID1_ADDR, ID2_ADDR, REV_ADDR}) begin
              io_we = 1'b0; // see RQ13
            end else if (!prot) begin
              // Single-cycle write or bit update, low 16 are plain storage
              io_we = 1'b1; // see RQ11
              io_wa = ea[m][11:0]; // see RQ6
              case (mreq[m].op)
                OP_SETB: io_wd = io_val[m] | (8'h01 << mreq[m].bit_sel); // see RQ5
                OP_CLRB: io_wd = io_val[m] & ~(8'h01 << mreq[m].bit_sel); // see RQ5
                default: io_wd = mreq[m].wdata;
              endcase
            end
          end
          SET_NV: begin
            // Mapped store loads the page buffer in one cycle
            nvb_we = 1'b1; // see RQ3
            nvb_wa = ea[m][4:0];
            nvb_wd = mreq[m].wdata;
            s_next.loaded[ea[m][4:0]] = 1'b1;
          end
          SET_SR0: begin
            s0_we = 1'b1; // see RQ9
            s0_wa = soff[m][13:0];
            s0_wd = mreq[m].wdata;
          end
          SET_SR1: begin
            s1_we = 1'b1; // see RQ9
            s1_wa = soff[m][13:0];
            s1_wd = mreq[m].wdata;
          end
          default: begin
            // Unmapped writes are dropped here, see RQ20
          end
        endcase
      end
    end
    // Program memory command: page ops ignore the word index
    s_next.pm.valid = (pm_op != PM_NONE);
    s_next.pm.op = pm_op;
    s_next.pm.program_page_index = pm_z[19:9]; // see RQ14
    s_next.pm.program_word_index = (pm_op == PM_READ) ? pm_z[8:1] : 8'h00; // see RQ15
    s_next.pm.hi_byte = (pm_op == PM_READ) && pm_z[0]; // see RQ15
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.lock <= LOCK_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Storage writes and nonvolatile commits
  always_ff @(posedge clk) begin
    if (io_we) begin
      io_mem[io_wa] <= io_wd;
    end
    if (s0_we) begin
      sram0[s0_wa] <= s0_wd;
    end
    if (s1_we) begin
      sram1[s1_wa] <= s1_wd;
    end
    if (nvb_we) begin
      nvb[nvb_wa] <= nvb_wd;
    end
    case (nv_op)
      NV_WR_PAGE: begin
        for (int i = 0; i < NV_PAGE_BYTES; i++) begin
          if (s_reg.loaded[i]) begin
            nv_mem[{nv_data_page_index, 5'(i)}] <= nvb[i]; // see RQ17
          end
        end
      end
      NV_WR_BYTE: begin
        if (s_reg.loaded[nv_data_byte_index]) begin
          nv_mem[nv_op_addr] <= nvb[nv_data_byte_index]; // see RQ17
        end
      end
      NV_ER_PAGE: begin
        for (int i = 0; i < NV_PAGE_BYTES; i++) begin
          nv_mem[{nv_data_page_index, 5'(i)}] <= 8'hff; // see RQ17
        end
      end
      NV_ER_BYTE: begin
        nv_mem[nv_op_addr] <= 8'hff; // see RQ17
      end
      default: begin
      end
    endcase
  end

  // Outputs straight from state
  assign mrsp = {s_reg.slot[2][0], s_reg.slot[1][0], s_reg.slot[0][0]};
  assign lock_state = s_reg.lock;
  assign pm_cmd = s_reg.pm;

  // Checks on timing, priority and protection
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_io_read_lat: assert property (mready[0] && isrd[0] && dset[0] == SET_IO // see RQ8
    |=> mrsp[0].valid) else $error("register read not answered in one cycle");
  a_sram_read_lat: assert property (mready[1] && isrd[1] && dset[1] inside {SET_SR0, SET_SR1} // see RQ9
    |-> ##2 mrsp[1].valid) else $error("SRAM read not answered in two cycles");
  a_nv_read_lat: assert property (mready[0] && isrd[0] && dset[0] == SET_NV // see RQ10
    |-> ##3 mrsp[0].valid) else $error("nonvolatile read not answered in three cycles");
  a_nv_burst_gap: assert property ((|(agnt[1] & isrd)) // see RQ10
    |=> agnt[1] == '0) else $error("nonvolatile reads closer than two cycles");
  a_beyond_zero: assert property (mready[1] && isrd[1] && dset[1] == SET_NONE // see RQ20
    |=> mrsp[1].valid && mrsp[1].data == 8'h00) else $error("unmapped read not zero");
  a_lock_guard: assert property (!ccp_open // see RQ12
    |=> $stable(s_reg.lock)) else $error("lock changed while protection closed");
  a_cpu_first: assert property (areq[2][0] && areq[2][1] // see RQ18
    |-> mready[0] && !mready[1]) else $error("CPU lost to DMA on same set");
  a_set_parallel: assert property (areq[0][0] && areq[2][1] // see RQ7
    |-> mready[0] && mready[1]) else $error("different sets not served together");
  a_short_range: assert property (mreq[0].valid && mreq[0].short_io // see RQ4
    |-> ea[0] <= SHORT_LAST) else $error("short path outside low range");
  a_map_off: assert property (!nv_map_en // see RQ2
    |-> dset[0] != SET_NV && agnt[1] == '0) else $error("unmapped store reached");

  c_three_masters: cover property (mready[0] && mready[1] && mready[2]);
  c_sram_burst: cover property (mready[1] && isrd[1] ##1 mready[1] && isrd[1]);
  c_page_commit: cover property (nv_op == NV_WR_PAGE && s_reg.loaded != '0);
  c_locked_write: cover property (mready[0] && !isrd[0] && ea[0][11:0] == CLK_LO && s_reg.lock[0]);
  c_gp_bit_set: cover property (mready[0] && mreq[0].op == OP_SETB && ea[0] <= GP_LAST);
endmodule

// >>> verification/dms_masters.sv
`timescale 1ns/10ps
// CPU, DMA read and DMA write masters on the router ports
module dms_masters (
  // Clock
  input wire logic clk,
  // Requests and answers
  output dms_pkg::dms_req_s [dms_pkg::NM-1:0] mreq,
  input wire logic [dms_pkg::NM-1:0] mready,
  input dms_pkg::dms_rsp_s [dms_pkg::NM-1:0] mrsp
);
  import dms_pkg::*;
  int cyc = 0; // Edge counter
  int rsp_cyc[NM][$]; // Edge of each answer
  logic [7:0] rsp_dat[NM][$]; // Data of each answer
  // Count edges and collect answer pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < NM; i++) begin
      if (mrsp[i].valid === 1'b1) begin
        rsp_cyc[i].push_back(cyc);
        rsp_dat[i].push_back(mrsp[i].data);
      end
    end
  end
  initial mreq = '0;
  // Present a request, hold it until taken; tk is the take edge or -1
  task automatic put(input int m, input dms_req_s r, input bit last, output int tk);
    #1;
    mreq[m] = r;
    tk = -1;
    for (int n = 0; n < 40 && tk < 0; n++) begin
      @(posedge clk);
      if (mready[m] === 1'b1) tk = cyc;
    end
    // Released bus shows no stale address or data
    if (last) begin
      #1;
      mreq[m].valid = 1'b0;
      mreq[m].addr = ~r.addr;
      mreq[m].wdata = ~r.wdata;
    end
  endtask
endmodule

// >>> verification/data_memory_subsystem_test.sv
`timescale 1ns/10ps
// Router bench with a reference model of the memory map
module data_memory_subsystem_test;
  import dms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dms_req_s [NM-1:0] mreq;
  logic [NM-1:0] mready;
  dms_rsp_s [NM-1:0] mrsp;
  logic nv_map_en = 1'b0;
  dms_nvop_e nv_op = NV_NONE;
  logic [11:0] nv_op_addr = 12'h000;
  logic ccp_open = 1'b0;
  logic [2:0] lock_state;
  dms_pmop_e pm_op = PM_NONE;
  logic [19:0] pm_z = 20'h00000;
  dms_pm_cmd_s pm_cmd;
  logic [7:0] mem[int]; // Register and SRAM model
  logic [7:0] nvm[int]; // Committed nonvolatile bytes
  logic [7:0] pbuf[32]; // Page buffer model
  bit [31:0] ld; // Loaded buffer bytes
  logic [2:0] lk = 3'h0; // Expected lock bits
  logic [15:0] a;
  logic [15:0] amap[8] = '{16'h0000, 16'h000f, 16'h0030, 16'h2000, 16'h5fff, 16'h6000, 16'h9fff, 16'ha000};
  logic [15:0] arb[2][3] = '{'{16'h2000, 16'h5fff, 16'h2010}, '{16'h000f, 16'h2000, 16'h6000}};
  logic [11:0] lka[3] = '{CLK_LO, EV_HI, WEX_LO};
  logic [7:0] exp_d[NM][$];
  int exp_t[NM][$];
  int tk_m[NM];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'hedb55843;
  int t0;
  always #25 clk = ~clk;
  dms_router uut (.clk(clk), .rst(rst), .mreq(mreq), .mready(mready), .mrsp(mrsp), .nv_map_en(nv_map_en),
    .nv_op(nv_op), .nv_op_addr(nv_op_addr), .ccp_open(ccp_open), .lock_state(lock_state), .pm_op(pm_op),
    .pm_z(pm_z), .pm_cmd(pm_cmd));
  dms_masters bus (.clk(clk), .mreq(mreq), .mready(mready), .mrsp(mrsp));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Issue one access, update the model, queue the expected answer
  task automatic issue(input int m, input dms_op_e op, input logic [15:0] ad, input logic [7:0] wd,
                       input bit last = 1, input logic sh = 1'b0, input logic [2:0] bs = 3'h0);
    logic [15:0] e;
    logic [7:0] d;
    int lat;
    bus.put(m, '{1'b1, op, sh, bs, ad, wd}, last, tk_m[m]);
    check(tk_m[m] >= 0, 1);
    e = sh ? {10'h000, ad[5:0]} : ad;
    lat = (e >= SRAM_BASE && e <= SRAM_LAST) ? 2 : (e >= NV_BASE && e < SRAM_BASE && nv_map_en) ? 3 : 1;
    d = 8'h00;
    if (op == OP_TSTB) begin
      lat = 1;
      if (e <= BIT_LAST) d = {7'h00, mem[e][bs]};
    end else if (e < NV_BASE) begin
      case (e)
        ID0_ADDR: d = ID0_DEF;
        ID1_ADDR: d = ID1_DEF;
        ID2_ADDR: d = ID2_DEF;
        REV_ADDR: d = REV_DEF;
        LOCK_ADDR: if (op == OP_WR && ccp_open) lk = wd[2:0];
        default: begin
          if (op == OP_RD) d = mem[e];
          else if (op == OP_WR && !(lk[0] && e >= CLK_LO && e <= CLK_HI || lk[1] && e >= EV_LO && e <= EV_HI
                   || lk[2] && e >= WEX_LO && e <= WEX_HI)) mem[e] = wd;
          else if (op == OP_SETB && e <= BIT_LAST) mem[e][bs] = 1'b1;
          else if (op == OP_CLRB && e <= BIT_LAST) mem[e][bs] = 1'b0;
        end
      endcase
    end else if (e < SRAM_BASE) begin
      if (nv_map_en && op == OP_RD) d = nvm[e[11:0]];
      if (nv_map_en && op == OP_WR) begin
        pbuf[e[4:0]] = wd;
        ld[e[4:0]] = 1'b1;
      end
    end else if (e <= SRAM_LAST) begin
      if (op == OP_RD) d = mem[e];
      if (op == OP_WR) mem[e] = wd;
    end
    if (op == OP_RD || op == OP_TSTB) begin
      exp_d[m].push_back(d);
      exp_t[m].push_back(tk_m[m] + lat);
    end
  endtask
  // Match queued expectations with the answers seen
  task automatic collect(input int m);
    for (int n = 0; n < 20 && bus.rsp_cyc[m].size() < exp_d[m].size(); n++) @(posedge clk);
    check(bus.rsp_cyc[m].size(), exp_d[m].size());
    while (exp_d[m].size() > 0 && bus.rsp_cyc[m].size() > 0) begin
      check(bus.rsp_dat[m].pop_front(), exp_d[m].pop_front());
      check(bus.rsp_cyc[m].pop_front(), exp_t[m].pop_front());
    end
    exp_d[m].delete();
    exp_t[m].delete();
    bus.rsp_cyc[m].delete();
    bus.rsp_dat[m].delete();
    #1;
  endtask
  // One nonvolatile commit cycle, then the model follows
  task automatic commit(input dms_nvop_e op, input logic [11:0] ad);
    @(posedge clk);
    #1 nv_op = op;
    nv_op_addr = ad;
    @(posedge clk);
    #1 nv_op = NV_NONE;
    nv_op_addr = ~ad;
    for (int k = 0; k < 32; k++) begin
      if (op == NV_WR_PAGE && ld[k]) nvm[{ad[11:5], k[4:0]}] = pbuf[k];
      if (op == NV_ER_PAGE) nvm[{ad[11:5], k[4:0]}] = 8'hff;
    end
    if (op == NV_WR_BYTE && ld[ad[4:0]]) nvm[ad] = pbuf[ad[4:0]];
    if (op == NV_ER_BYTE) nvm[ad] = 8'hff;
    ld = (op == NV_WR_PAGE) ? 32'h0 : (op == NV_WR_BYTE) ? ld & ~(32'h1 << ad[4:0]) : ld;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    check(lock_state, 3'h0);
    check(pm_cmd, '0);
    check(mrsp, '0);
    #1 rst = 1'b0;
    @(posedge clk);
    foreach (amap[i]) begin
      issue(i % NM, OP_WR, amap[i], 8'($random(seed)));
      issue(i % NM, OP_RD, amap[i], 8'h00);
      collect(i % NM);
    end
    done("map");
    issue(0, OP_WR, 16'hffc7, 8'($random(seed)), 1, 1'b1);
    issue(1, OP_WR, 16'h0020, 8'h00);
    for (int b = 0; b < 16; b++) begin
      t0 = $random(seed);
      a = t0[4] ? 16'h0020 : 16'h0007;
      issue(0, t0[3] ? OP_CLRB : OP_SETB, a, 8'h00, 1, 1'b0, t0[2:0]);
      issue(0, OP_TSTB, a, 8'h00, 1, 1'b0, t0[2:0]);
    end
    issue(0, OP_RD, 16'h0007, 8'h00);
    issue(0, OP_RD, 16'h0020, 8'h00);
    collect(0);
    collect(1);
    done("bits");
    nv_map_en = 1'b1;
    issue(2, OP_WR, 16'h1003, 8'($random(seed)));
    issue(2, OP_WR, 16'h1011, 8'($random(seed)));
    commit(NV_WR_PAGE, 12'h040);
    issue(2, OP_WR, 16'h1005, 8'($random(seed)));
    commit(NV_WR_BYTE, 12'h085);
    commit(NV_ER_BYTE, 12'h043);
    commit(NV_ER_PAGE, 12'h0e0);
    issue(0, OP_RD, 16'h1051, 8'h00);
    issue(0, OP_RD, 16'h1085, 8'h00);
    issue(1, OP_RD, 16'h1043, 8'h00, 0);
    t0 = tk_m[1];
    issue(1, OP_RD, 16'h10ff, 8'h00);
    check(tk_m[1] - t0, 2);
    issue(1, OP_RD, 16'h2000, 8'h00, 0);
    t0 = tk_m[1];
    issue(1, OP_RD, 16'h5fff, 8'h00, 0);
    check(tk_m[1] - t0, 1);
    issue(1, OP_RD, 16'h9fff, 8'h00);
    collect(0);
    collect(1);
    nv_map_en = 1'b0;
    issue(0, OP_WR, 16'h1051, 8'h5a);
    issue(0, OP_RD, 16'h1051, 8'h00);
    collect(0);
    done("nonvolatile");
    foreach (lka[i]) issue(0, OP_WR, {4'h0, lka[i]}, 8'($random(seed)));
    issue(0, OP_WR, {4'h0, LOCK_ADDR}, 8'h07);
    ccp_open = 1'b1;
    issue(0, OP_WR, {4'h0, LOCK_ADDR}, 8'h07);
    ccp_open = 1'b0;
    @(posedge clk);
    #1 check(lock_state, lk);
    foreach (lka[i]) issue(0, OP_WR, {4'h0, lka[i]}, 8'($random(seed)));
    foreach (lka[i]) issue(0, OP_RD, {4'h0, lka[i]}, 8'h00);
    issue(0, OP_WR, {4'h0, ID0_ADDR}, 8'h00);
    for (int k = 0; k < 4; k++) issue(0, OP_RD, {4'h0, ID0_ADDR} + 16'(k), 8'h00);
    collect(0);
    done("protection");
    for (int r = 0; r < 2; r++) begin
      fork
        issue(0, OP_RD, arb[r][0], 8'h00);
        issue(1, OP_RD, arb[r][1], 8'h00);
        issue(2, OP_WR, arb[r][2], 8'($random(seed)));
      join
      check(tk_m[1] - tk_m[0], r ? 0 : 1);
      check(tk_m[2] - tk_m[0], r ? 0 : 2);
      issue(2, OP_RD, arb[r][2], 8'h00);
      for (int m = 0; m < NM; m++) collect(m);
    end
    done("arbitration");
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      #1 pm_op = dms_pmop_e'(k);
      pm_z = 20'($random(seed));
      @(posedge clk);
      #1 pm_op = PM_NONE;
      check({pm_cmd.valid, pm_cmd.op, pm_cmd.program_page_index}, {1'b1, 2'(k), pm_z[19:9]});
      check(pm_cmd.program_word_index, k == 1 ? pm_z[8:1] : 8'h00);
      if (k == 1) check(pm_cmd.hi_byte, pm_z[0]);
    end
    done("program");
    conclude();
  end
  // Hang guard
  initial begin
    #2000000;
    n_fail++;
    conclude();
  end
endmodule
